// ==== core/pll_regs_pkg.sv ====
// Register map, field layout and reset values of the PLL status and configuration block
package pll_regs_pkg;

  localparam logic [31:0] ADDR_PLL_TRIGGER = 32'hFF42_5000;
  localparam logic [31:0] ADDR_PLL_STATUS = 32'hFF42_5004;
  localparam logic [31:0] ADDR_PLL_FREQ_CONTROL = 32'hFF42_5008;
  localparam logic [31:0] ADDR_PLL_LOCK_TIME = 32'hFF42_500C;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFF42_5010;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hFF42_5014;

  localparam int TRG_START_BIT = 0;
  localparam int TRG_STOP_BIT = 1;

  localparam int STAT_STABLE_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_ENABLED_BIT = 2;

  localparam int POSTDIV_LSB = 8;
  localparam int POSTDIV_W = 2;
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 5;
  localparam int LOCKSEL_LSB = 0;
  localparam int LOCKSEL_W = 3;

  localparam int IRQ_LOCKED_BIT = 0;
  localparam int IRQ_STOPPED_BIT = 1;
  localparam int IRQ_W = 2;

  localparam logic [31:0] PLL_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_FREQ_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_LOCK_TIME_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // Lock wait is 2^(LOCK_BASE_EXP + code) counter-clock ticks
  localparam int LOCK_BASE_EXP = 7;
  localparam int LOCK_CNT_W = 16;

  typedef enum logic [1:0] {PLL_OFF, PLL_LOCKING, PLL_LOCKED} pll_state_t;

endpackage

// ==== core/osc_sync.sv ====
// Two-stage synchroniser with rising-edge pulse for an oscillator clock or level
`timescale 1ns/1ps
module osc_sync (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic asyncIn,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = asyncIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // Only the second and third stages feed logic; s1 may be metastable
  assign level = st.s2;
  assign rise = st.s2 & ~st.s3;

endmodule

// ==== core/lock_timer.sv ====
// Stabilization counter: counts oscillator ticks while running, flags done at the target
`timescale 1ns/1ps
module lock_timer
  import pll_regs_pkg::*;
#(
  parameter int BASE_EXP = LOCK_BASE_EXP
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run,
  input wire logic tick,
  input wire logic [LOCKSEL_W-1:0] code,
  output logic done
);

  typedef struct packed {
    logic [LOCK_CNT_W-1:0] count;
    logic done;
  } timer_t;

  timer_t st;
  timer_t next_st;
  logic [LOCK_CNT_W-1:0] target;
  logic [LOCK_CNT_W-1:0] countInc;

  // 2^(BASE_EXP + code) ticks; with code 7 that is 16384
  always_comb begin
    target = LOCK_CNT_W'(16'h0001) << (LOCK_CNT_W'(BASE_EXP) + LOCK_CNT_W'(code));
    countInc = st.count + LOCK_CNT_W'(16'h0001);
  end

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.count = '0;
      next_st.done = 1'b0;
    end else if (tick && !st.done) begin
      next_st.count = countInc;
      if (countInc == target) begin
        next_st.done = 1'b1;
      end
    end
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign done = st.done;

endmodule

// ==== core/pll_status_config_regs.sv ====
// PLL status, frequency control and lock-time registers with start/stop and lock sequencing
//
// How it works
// - Status word is read-only, whole 32-bit reads; writes to it are ignored.
// - Any reset clears status, control and lock-time registers to zero.
// - Status bit 2 reads 1 while the PLL is enabled.
// - Status bit 1 reads 1 while the PLL is active.
// - Status bit 0 reads 1 once the PLL output is stable.
// - Control and lock-time writes are taken only while the PLL is disabled.
// - Control register holds a 32-bit read/write frequency setting.
// - Multiplier value equals the 5-bit field plus one.
// - Lock-time register is 32-bit read/write; bits 2:0 select the wait.
// - Wait lasts 2^(7+code) counter ticks: 128 up to 16384.
// - Counter normally ticks from the high-speed internal oscillator.
// - With high-speed oscillator disabled, counter ticks from the low-speed oscillator.
// - Start trigger written 1 starts an inactive PLL; reads back 0.
// - Stop trigger written 1 stops an active PLL; reads back 0.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module pll_status_config_regs
  import pll_regs_pkg::*;
#(
  parameter int BASE_EXP = LOCK_BASE_EXP
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdata,
  input wire logic hsOscClk,
  input wire logic lsOscClk,
  input wire logic hsOscEnabledFlag,
  output logic pllRun,
  output logic pllStableFlag,
  output logic [POSTDIV_W-1:0] postDividerSel,
  output logic [MULT_W:0] multiplierValue,
  output logic irq
);

  typedef struct packed {
    pll_state_t state;
    logic pllEnabledFlag;
    logic pllActiveFlag;
    logic pllStableFlag;
    logic [31:0] freqControl;
    logic [31:0] lockTime;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqMask;
    logic [POSTDIV_W-1:0] postDiv;
    logic [MULT_W:0] multValue;
    logic [31:0] rdata;
    logic irq;
  } regs_t;

  regs_t st;
  regs_t next_st;

  logic hsEnabledSync;
  logic hsTick;
  logic lsTick;
  logic counterTick;
  logic lockDone;
  logic wrTrigger;
  logic wrControl;
  logic wrLockTime;
  logic wrIrqStatus;
  logic wrIrqMask;
  logic startReq;
  logic stopReq;
  logic [IRQ_W-1:0] irqEvents;
  logic [31:0] statusWord;
  logic [31:0] readMux;

  // Oscillator clocks are far slower than clk_sys, so they are sampled, not used as clocks
  osc_sync u_hs_clk (
    .clk_sys(clk_sys),
    .srst(srst),
    .asyncIn(hsOscClk),
    .level(),
    .rise(hsTick)
  );

  osc_sync u_ls_clk (
    .clk_sys(clk_sys),
    .srst(srst),
    .asyncIn(lsOscClk),
    .level(),
    .rise(lsTick)
  );

  osc_sync u_hs_en (
    .clk_sys(clk_sys),
    .srst(srst),
    .asyncIn(hsOscEnabledFlag),
    .level(hsEnabledSync),
    .rise()
  );

  // Source switches automatically; a switch mid-wait keeps the count already reached
  always_comb begin
    if (hsEnabledSync) begin
      counterTick = hsTick;
    end else begin
      counterTick = lsTick;
    end
  end

  lock_timer #(
    .BASE_EXP(BASE_EXP)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(st.pllActiveFlag),
    .tick(counterTick),
    .code(st.lockTime[LOCKSEL_LSB +: LOCKSEL_W]),
    .done(lockDone)
  );

  // Register decode
  always_comb begin
    wrTrigger = wrEn && (addr == ADDR_PLL_TRIGGER);
    wrControl = wrEn && (addr == ADDR_PLL_FREQ_CONTROL);
    wrLockTime = wrEn && (addr == ADDR_PLL_LOCK_TIME);
    wrIrqStatus = wrEn && (addr == ADDR_IRQ_STATUS);
    wrIrqMask = wrEn && (addr == ADDR_IRQ_MASK);
    startReq = wrTrigger && wdata[TRG_START_BIT] && !st.pllActiveFlag;
    stopReq = wrTrigger && wdata[TRG_STOP_BIT] && st.pllActiveFlag;
  end

  always_comb begin
    statusWord = PLL_STATUS_RST;
    statusWord[STAT_ENABLED_BIT] = st.pllEnabledFlag;
    statusWord[STAT_ACTIVE_BIT] = st.pllActiveFlag;
    statusWord[STAT_STABLE_BIT] = st.pllStableFlag;
  end

  // Triggers read back as zero; unmapped addresses read zero
  always_comb begin
    case (addr)
      ADDR_PLL_TRIGGER: readMux = 32'h0000_0000;
      ADDR_PLL_STATUS: readMux = statusWord;
      ADDR_PLL_FREQ_CONTROL: readMux = st.freqControl;
      ADDR_PLL_LOCK_TIME: readMux = st.lockTime;
      ADDR_IRQ_STATUS: readMux = {{(32-IRQ_W){1'b0}}, st.irqStatus};
      ADDR_IRQ_MASK: readMux = {{(32-IRQ_W){1'b0}}, st.irqMask};
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    irqEvents = '0;

    case (st.state)
      PLL_OFF: begin
        if (startReq) begin
          next_st.state = PLL_LOCKING;
          next_st.pllEnabledFlag = 1'b1;
          next_st.pllActiveFlag = 1'b1;
        end
      end
      PLL_LOCKING: begin
        if (stopReq) begin
          next_st.state = PLL_OFF;
          next_st.pllEnabledFlag = 1'b0;
          next_st.pllActiveFlag = 1'b0;
          irqEvents[IRQ_STOPPED_BIT] = 1'b1;
        end else if (lockDone) begin
          next_st.state = PLL_LOCKED;
          next_st.pllStableFlag = 1'b1;
          irqEvents[IRQ_LOCKED_BIT] = 1'b1;
        end
      end
      PLL_LOCKED: begin
        if (stopReq) begin
          next_st.state = PLL_OFF;
          next_st.pllEnabledFlag = 1'b0;
          next_st.pllActiveFlag = 1'b0;
          next_st.pllStableFlag = 1'b0;
          irqEvents[IRQ_STOPPED_BIT] = 1'b1;
        end
      end
      default: begin
        next_st.state = PLL_OFF;
        next_st.pllEnabledFlag = 1'b0;
        next_st.pllActiveFlag = 1'b0;
        next_st.pllStableFlag = 1'b0;
      end
    endcase

    // Refused while enabled, so a running PLL never sees its setting change under it
    if (wrControl && !st.pllEnabledFlag) begin
      next_st.freqControl = wdata;
    end
    if (wrLockTime && !st.pllEnabledFlag) begin
      next_st.lockTime = wdata;
    end

    next_st.postDiv = next_st.freqControl[POSTDIV_LSB +: POSTDIV_W];
    next_st.multValue = {1'b0, next_st.freqControl[MULT_LSB +: MULT_W]} + 6'h01;

    if (wrIrqMask) begin
      next_st.irqMask = wdata[IRQ_W-1:0];
    end
    // Write-one-to-clear, but a new event in the same cycle wins
    if (wrIrqStatus) begin
      next_st.irqStatus = st.irqStatus & ~wdata[IRQ_W-1:0];
    end
    next_st.irqStatus = next_st.irqStatus | irqEvents;
    next_st.irq = |(next_st.irqStatus & next_st.irqMask);

    if (rdEn) begin
      next_st.rdata = readMux;
    end else begin
      next_st.rdata = 32'h0000_0000;
    end

    if (srst) begin
      next_st.state = PLL_OFF;
      next_st.pllEnabledFlag = 1'b0;
      next_st.pllActiveFlag = 1'b0;
      next_st.pllStableFlag = 1'b0;
      next_st.freqControl = PLL_FREQ_CONTROL_RST;
      next_st.lockTime = PLL_LOCK_TIME_RST;
      next_st.irqStatus = IRQ_RST;
      next_st.irqMask = IRQ_RST;
      next_st.postDiv = PLL_FREQ_CONTROL_RST[POSTDIV_LSB +: POSTDIV_W];
      next_st.multValue = {1'b0, PLL_FREQ_CONTROL_RST[MULT_LSB +: MULT_W]} + 6'h01;
      next_st.rdata = 32'h0000_0000;
      next_st.irq = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign rdata = st.rdata;
  assign pllRun = st.pllActiveFlag;
  assign pllStableFlag = st.pllStableFlag;
  assign postDividerSel = st.postDiv;
  assign multiplierValue = st.multValue;
  assign irq = st.irq;

endmodule

// ==== dv/pll_regs_checker.sv ====
// Port-level assertions for the PLL register block
`timescale 1ns/1ps
module pll_regs_checker
  import pll_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdata,
  input wire logic pllRun,
  input wire logic pllStableFlag,
  input wire logic [POSTDIV_W-1:0] postDividerSel,
  input wire logic [MULT_W:0] multiplierValue,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire trgWr = wrEn && addr == ADDR_PLL_TRIGGER;
  wire ctlWr = wrEn && addr == ADDR_PLL_FREQ_CONTROL;
  AST_RESET: assert property (disable iff (1'h0) srst |=>
    rdata == 32'h0 && !pllRun && !pllStableFlag && !irq) else $error("reset state wrong");
  AST_RD_IDLE: assert property (!rdEn |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  AST_STATUS: assert property (rdEn && addr == ADDR_PLL_STATUS |=>
    rdata == {29'h0, $past(pllRun), $past(pllRun), $past(pllStableFlag)})
    else $error("status word wrong");
  AST_START: assert property (trgWr && wdata[0] && !pllRun |=> pllRun)
    else $error("start ignored");
  AST_STOP: assert property (trgWr && wdata[1] && !wdata[0] && pllRun |=>
    !pllRun && !pllStableFlag) else $error("stop ignored");
  AST_CTRL_LOCKED: assert property (ctlWr && pllRun |=>
    $stable(postDividerSel) && $stable(multiplierValue)) else $error("control changed");
  AST_CTRL_WR: assert property (ctlWr && !pllRun |=> postDividerSel == $past(wdata[9:8])
    && multiplierValue == {1'h0, $past(wdata[4:0])} + 6'h1) else $error("control not taken");
  AST_STABLE_RUN: assert property (pllStableFlag |-> pllRun)
    else $error("stable while stopped");
  AST_STABLE_LATE: assert property ($rose(pllRun) |-> !pllStableFlag [*3])
    else $error("stable too early");
  cover property ($rose(pllStableFlag));
  cover property (trgWr && wdata[1] && pllRun);
  cover property (ctlWr && pllRun);
endmodule
bind pll_status_config_regs pll_regs_checker pll_regs_checker_i (.clk_sys, .srst, .addr,
  .wdata, .wrEn, .rdEn, .rdata, .pllRun, .pllStableFlag, .postDividerSel, .multiplierValue, .irq);

// ==== dv/pll_status_config_regs_bench.sv ====
// Self-checking bench for the PLL status and configuration registers
`timescale 1ns/1ps
module pll_status_config_regs_bench
  import pll_regs_pkg::*;
;
  logic clk_sys = 0, srst = 1, wrEn = 0, rdEn = 0, hsOscClk = 0, lsOscClk = 0;
  logic hsOscEnabledFlag = 1, pllRun, pllStableFlag, irq;
  logic [31:0] addr = 0, wdata = 0, rdata;
  logic [1:0] postDividerSel;
  logic [5:0] multiplierValue;
  int fail_count = 0, checks_done = 0;
  pll_status_config_regs #(.BASE_EXP(1)) pll_status_config_regs_i (.clk_sys, .srst, .addr,
    .wdata, .wrEn, .rdEn, .rdata, .hsOscClk, .lsOscClk, .hsOscEnabledFlag, .pllRun,
    .pllStableFlag, .postDividerSel, .multiplierValue, .irq);
  initial forever #12.5 clk_sys = ~clk_sys;
  // Oscillators: 4 and about 16 system cycles, offset so edges never align with clk_sys rising edges
  initial forever #50 hsOscClk = ~hsOscClk;
  initial forever #200.2 lsOscClk = ~lsOscClk;
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wrEn <= 1'h1;
    @(posedge clk_sys);
    wrEn <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    @(posedge clk_sys);
    addr <= a;
    rdEn <= 1'h1;
    @(posedge clk_sys);
    rdEn <= 1'h0;
    #1 chk(rdata, exp);
  endtask
  task automatic t_reset;
    logic [31:0] regs[7] = '{ADDR_PLL_TRIGGER, ADDR_PLL_STATUS, ADDR_PLL_FREQ_CONTROL,
      ADDR_PLL_LOCK_TIME, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, 32'hFF42_5020};
    foreach (regs[i]) rd(regs[i], 32'h0);
    chk({26'h0, multiplierValue}, 32'h1);
  endtask
  task automatic t_regs;
    wr(ADDR_PLL_FREQ_CONTROL, 32'h21F);
    chk({24'h0, postDividerSel, multiplierValue}, 32'hA0);
    rd(ADDR_PLL_FREQ_CONTROL, 32'h21F);
    wr(ADDR_PLL_FREQ_CONTROL, 32'h304);
    chk({24'h0, postDividerSel, multiplierValue}, 32'hC5);
    wr(ADDR_PLL_LOCK_TIME, 32'h7);
    rd(ADDR_PLL_LOCK_TIME, 32'h7);
    wr(ADDR_PLL_STATUS, 32'h7);
    rd(ADDR_PLL_STATUS, 32'h0);
  endtask
  // Lock wait in system cycles; oscillator phase and sync give a window, not an exact count
  task automatic t_lock(input logic [2:0] code, input logic hsOn, input int per);
    int n, t;
    n = 0;
    t = 2 ** (1 + code);
    @(posedge clk_sys);
    hsOscEnabledFlag <= hsOn;
    wr(ADDR_PLL_LOCK_TIME, {29'h0, code});
    wr(ADDR_PLL_TRIGGER, 32'h1);
    chk({31'h0, pllStableFlag}, 32'h0);
    while (pllStableFlag !== 1'h1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(n >= (t - 1) * per && n <= (t + 1) * per + 8), 32'h1);
    rd(ADDR_PLL_STATUS, 32'h7);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_PLL_FREQ_CONTROL, 32'h21F);
    rd(ADDR_PLL_FREQ_CONTROL, 32'h304);
    wr(ADDR_PLL_TRIGGER, 32'h1);
    rd(ADDR_PLL_STATUS, 32'h7);
    wr(ADDR_PLL_TRIGGER, 32'h2);
    rd(ADDR_PLL_STATUS, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h2);
  endtask
  // Reset in mid-run: a running PLL and written registers must all clear
  task automatic t_midreset;
    wr(ADDR_PLL_FREQ_CONTROL, 32'h21F);
    wr(ADDR_PLL_LOCK_TIME, 32'h5);
    wr(ADDR_IRQ_MASK, 32'h3);
    rd(ADDR_IRQ_MASK, 32'h3);
    wr(ADDR_PLL_TRIGGER, 32'h1);
    chk({31'h0, pllRun}, 32'h1);
    @(posedge clk_sys);
    srst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'h0;
    #1;
    chk({29'h0, pllRun, pllStableFlag, irq}, 32'h0);
    chk({24'h0, postDividerSel, multiplierValue}, 32'h1);
    rd(ADDR_PLL_STATUS, 32'h0);
    rd(ADDR_PLL_FREQ_CONTROL, 32'h0);
    rd(ADDR_PLL_LOCK_TIME, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #500us;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'h0;
    t_reset();
    t_regs();
    wr(ADDR_IRQ_MASK, 32'h1);
    t_lock(3'h0, 1'h1, 4);
    t_lock(3'h3, 1'h1, 4);
    t_lock(3'h7, 1'h1, 4);
    t_lock(3'h1, 1'h0, 16);
    t_midreset();
    end_of_test();
  end
endmodule
